// file: design/gpp_pkg.sv
// constants and types shared by the gpio port block
package gpp_pkg;
    // ********************
    // sizes
    // ********************
    localparam int unsigned NPIN   = 16;
    localparam int unsigned NFUNC  = 8;
    localparam int unsigned ADDR_W = 6;

    // ********************
    // register offsets (byte addresses)
    // ********************
    localparam logic [5:0] OFS_MODE  = 6'h00;
    localparam logic [5:0] OFS_OTYPE = 6'h04;
    localparam logic [5:0] OFS_SPEED = 6'h08;
    localparam logic [5:0] OFS_PUPD  = 6'h0C;
    localparam logic [5:0] OFS_IDATA = 6'h10;
    localparam logic [5:0] OFS_ODATA = 6'h14;
    localparam logic [5:0] OFS_BSC   = 6'h18;
    localparam logic [5:0] OFS_LOCK  = 6'h1C;
    localparam logic [5:0] OFS_AFL   = 6'h20;
    localparam logic [5:0] OFS_AFH   = 6'h24;
    localparam logic [5:0] OFS_CLR   = 6'h28;

    // ********************
    // reset values
    // ********************
    localparam logic [31:0] CFG_RST     = 32'h0000_0000;
    localparam logic [31:0] MODE_RST_A  = 32'h2800_0000;
    localparam logic [31:0] SPEED_RST_A = 32'h0C00_0000;
    localparam logic [31:0] PUPD_RST_A  = 32'h2400_0000;

    // ********************
    // field encodings
    // ********************
    localparam int unsigned LOCK_KEY_POS = 16;
    localparam int unsigned SET_LO       = 0;
    localparam int unsigned CLR_LO       = 16;

    typedef enum logic [1:0] {
        MODE_IN  = 2'h0,
        MODE_OUT = 2'h1,
        MODE_ALT = 2'h2,
        MODE_ANA = 2'h3
    } gpp_mode_e;

    typedef enum logic [1:0] {
        PULL_NONE = 2'h0,
        PULL_UP   = 2'h1,
        PULL_DOWN = 2'h2
    } gpp_pull_e;

    // lock sequence: key 1, key 0, key 1, then read
    typedef enum logic [1:0] {
        LK_IDLE = 2'h0,
        LK_ONE  = 2'h1,
        LK_ZERO = 2'h3,
        LK_TWO  = 2'h2
    } gpp_lock_e;
endpackage : gpp_pkg

// file: design/gpp_pad_if.sv
// configuration and pad signals between port core and pad multiplexer
`timescale 1ns/1ps
interface gpp_pad_if;
    logic [31:0]  mode;
    logic [15:0]  otype;
    logic [31:0]  pupd;
    logic [15:0]  odata;
    logic [63:0]  afsel;
    logic [127:0] af_out;
    logic [127:0] af_oe;
    logic [15:0]  force_off;
    logic [15:0]  out;
    logic [15:0]  oe;
    logic [15:0]  pu;
    logic [15:0]  pd;
    logic [15:0]  ana;

    modport ctrl (output mode, otype, pupd, odata, afsel, af_out, af_oe,
                  output force_off, input out, oe, pu, pd, ana);
    modport mux  (input mode, otype, pupd, odata, afsel, af_out, af_oe,
                  input force_off, output out, oe, pu, pd, ana);
endinterface : gpp_pad_if

// file: design/gpp_pad_mux.sv
// per-pin driver, pull and function multiplexer
`timescale 1ns/1ps
module gpp_pad_mux
    import gpp_pkg::*;
(
    gpp_pad_if.mux pif // configuration in, pad controls out
);
    for (genvar p = 0; p < NPIN; p++) begin : g_pin
        logic [1:0] md;
        logic [1:0] pl;
        logic [3:0] sel;
        logic       af_o;
        logic       af_e;
        assign md  = pif.mode[2*p +: 2];
        assign pl  = pif.pupd[2*p +: 2];
        assign sel = pif.afsel[4*p +: 4];

        // one function per pin; selectors above seven reach nothing
        always_comb begin
            af_o = 1'b0;
            af_e = 1'b0;
            if (!sel[3]) begin
                af_o = pif.af_out[NFUNC*p + 32'(sel[2:0])];
                af_e = pif.af_oe[NFUNC*p + 32'(sel[2:0])];
            end
        end

        always_comb begin
            pif.out[p] = 1'b0;
            pif.oe[p]  = 1'b0;
            pif.pu[p]  = (pl == PULL_UP);
            pif.pd[p]  = (pl == PULL_DOWN);
            pif.ana[p] = 1'b0;
            if (pif.force_off[p] || md == MODE_ANA) begin
                pif.pu[p]  = 1'b0;
                pif.pd[p]  = 1'b0;
                pif.ana[p] = 1'b1;
            end else if (md == MODE_OUT) begin
                if (pif.otype[p]) begin
                    pif.oe[p] = ~pif.odata[p];
                end else begin
                    pif.out[p] = pif.odata[p];
                    pif.oe[p]  = 1'b1;
                end
            end else if (md == MODE_ALT) begin
                if (pif.otype[p]) begin
                    pif.oe[p] = af_e & ~af_o;
                end else begin
                    pif.out[p] = af_o;
                    pif.oe[p]  = af_e;
                end
            end
        end
    end
endmodule : gpp_pad_mux

// file: design/gpp_port.sv
// gpio port: registers, lock, input sampling and registered pad controls
`timescale 1ns/1ps
module gpp_port
    import gpp_pkg::*;
#(
    parameter bit          PORT_A        = 1'b1,     // debug pin reset values
    parameter bit          HAS_LOCK      = 1'b1,     // lock register present
    parameter logic [15:0] FAST_OSC_PINS = 16'h0000, // pins of fast oscillator
    parameter logic [15:0] SLOW_OSC_PINS = 16'h0000, // pins of slow oscillator
    parameter logic [15:0] BACKUP_PINS   = 16'h0000  // backup-domain pins
) (
    input  wire logic               CLK_I,          // 40 MHz clock
    input  wire logic               RESET_N_I,      // sync reset, low
    input  wire logic [ADDR_W-1:0]  ADDR_I,         // byte address
    input  wire logic [31:0]        WDATA_I,        // write data
    input  wire logic               WR_I,           // write strobe
    input  wire logic               RD_I,           // read strobe
    output logic      [31:0]        RDATA_O,        // read data, next cycle
    input  wire logic [15:0]        PAD_IN_I,       // pin levels
    output logic      [15:0]        PAD_OUT_O,      // pin drive level
    output logic      [15:0]        PAD_OE_O,       // pin driver enable
    output logic      [15:0]        PULL_UP_O,      // weak pull-up on
    output logic      [15:0]        PULL_DOWN_O,    // weak pull-down on
    output logic      [15:0]        ANALOG_O,       // digital path off
    output logic      [31:0]        SPEED_O,        // speed grade per pin
    output logic      [15:0]        AF_IN_O,        // pin levels to peripherals
    input  wire logic [127:0]       AF_OUT_I,       // peripheral drive, 8/pin
    input  wire logic [127:0]       AF_OE_I,        // peripheral enable, 8/pin
    input  wire logic               FAST_OSC_EN_I,  // fast oscillator enabled
    input  wire logic               SLOW_OSC_EN_I,  // slow oscillator enabled
    input  wire logic               CORE_OFF_I,     // core supply is off
    input  wire logic               RTC_OWN_I       // rtc controls backup pins
);
    // ********************
    // state
    // ********************
    logic [31:0] mode_q;
    logic [15:0] otype_q;
    logic [31:0] speed_q;
    logic [31:0] pupd_q;
    logic [15:0] odata_q;
    logic [15:0] odata_d;
    logic [31:0] afl_q;
    logic [31:0] afh_q;
    logic [15:0] lock_q;
    logic        key_q;
    gpp_lock_e   lk_q;
    logic [15:0] sync1_q;
    logic [15:0] sync2_q;
    logic [15:0] idata_q;
    logic [31:0] rdata_q;

    logic [15:0] lk1;
    logic [31:0] lk2;
    logic [63:0] lk4;
    logic        wr_mode;
    logic        wr_otype;
    logic        wr_speed;
    logic        wr_pupd;
    logic        wr_odata;
    logic        wr_bsc;
    logic        wr_lock;
    logic        wr_afl;
    logic        wr_afh;
    logic        wr_clr;
    logic        rd_lock;

    gpp_pad_if pif ();

    // ********************
    // write decode
    // ********************
    always_comb begin
        wr_mode  = 1'b0;
        wr_otype = 1'b0;
        wr_speed = 1'b0;
        wr_pupd  = 1'b0;
        wr_odata = 1'b0;
        wr_bsc   = 1'b0;
        wr_lock  = 1'b0;
        wr_afl   = 1'b0;
        wr_afh   = 1'b0;
        wr_clr   = 1'b0;
        if (!WR_I) begin
            wr_mode = 1'b0;
        end else if (ADDR_I == OFS_MODE) begin
            wr_mode = 1'b1;
        end else if (ADDR_I == OFS_OTYPE) begin
            wr_otype = 1'b1;
        end else if (ADDR_I == OFS_SPEED) begin
            wr_speed = 1'b1;
        end else if (ADDR_I == OFS_PUPD) begin
            wr_pupd = 1'b1;
        end else if (ADDR_I == OFS_ODATA) begin
            wr_odata = 1'b1;
        end else if (ADDR_I == OFS_BSC) begin
            wr_bsc = 1'b1;
        end else if (ADDR_I == OFS_LOCK) begin
            wr_lock = HAS_LOCK;
        end else if (ADDR_I == OFS_AFL) begin
            wr_afl = 1'b1;
        end else if (ADDR_I == OFS_AFH) begin
            wr_afh = 1'b1;
        end else if (ADDR_I == OFS_CLR) begin
            wr_clr = 1'b1;
        end
    end

    assign rd_lock = RD_I && (ADDR_I == OFS_LOCK) && HAS_LOCK;

    // ********************
    // lock masks per field width
    // ********************
    assign lk1 = key_q ? lock_q : 16'h0000;
    for (genvar p = 0; p < NPIN; p++) begin : g_lk
        assign lk2[2*p +: 2] = {2{lk1[p]}};
        assign lk4[4*p +: 4] = {4{lk1[p]}};
    end

    // ********************
    // configuration registers
    // ********************
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            mode_q <= PORT_A ? MODE_RST_A : CFG_RST;
        end else if (wr_mode) begin
            mode_q <= (mode_q & lk2) | (WDATA_I & ~lk2);
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            otype_q <= CFG_RST[15:0];
        end else if (wr_otype) begin
            otype_q <= (otype_q & lk1) | (WDATA_I[15:0] & ~lk1);
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            speed_q <= PORT_A ? SPEED_RST_A : CFG_RST;
        end else if (wr_speed) begin
            speed_q <= (speed_q & lk2) | (WDATA_I & ~lk2);
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            pupd_q <= PORT_A ? PUPD_RST_A : CFG_RST;
        end else if (wr_pupd) begin
            pupd_q <= (pupd_q & lk2) | (WDATA_I & ~lk2);
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            afl_q <= CFG_RST;
            afh_q <= CFG_RST;
        end else if (wr_afl) begin
            afl_q <= (afl_q & lk4[31:0]) | (WDATA_I & ~lk4[31:0]);
        end else if (wr_afh) begin
            afh_q <= (afh_q & lk4[63:32]) | (WDATA_I & ~lk4[63:32]);
        end
    end

    // ********************
    // output data with set and clear
    // ********************
    always_comb begin
        odata_d = odata_q;
        if (wr_odata) begin
            odata_d = WDATA_I[15:0];
        end else if (wr_bsc) begin
            // set applied after clear so set wins on both
            odata_d = (odata_q & ~WDATA_I[CLR_LO +: 16])
                    | WDATA_I[SET_LO +: 16];
        end else if (wr_clr) begin
            odata_d = odata_q & ~WDATA_I[15:0];
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            odata_q <= CFG_RST[15:0];
        end else begin
            odata_q <= odata_d;
        end
    end

    // ********************
    // lock key sequence
    // ********************
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            lock_q <= CFG_RST[15:0];
        end else if (wr_lock && !key_q) begin
            lock_q <= WDATA_I[15:0];
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            lk_q  <= LK_IDLE;
            key_q <= 1'b0;
        end else if (!key_q) begin
            case (lk_q)
                LK_IDLE: begin
                    if (wr_lock && WDATA_I[LOCK_KEY_POS]) begin
                        lk_q <= LK_ONE;
                    end
                end
                LK_ONE: begin
                    if (wr_lock) begin
                        lk_q <= (!WDATA_I[LOCK_KEY_POS]
                                 && WDATA_I[15:0] == lock_q)
                                ? LK_ZERO : LK_IDLE;
                    end
                end
                LK_ZERO: begin
                    if (wr_lock) begin
                        lk_q <= (WDATA_I[LOCK_KEY_POS]
                                 && WDATA_I[15:0] == lock_q)
                                ? LK_TWO : LK_IDLE;
                    end
                end
                LK_TWO: begin
                    if (wr_lock) begin
                        lk_q <= LK_IDLE;
                    end else if (rd_lock) begin
                        key_q <= 1'b1;
                        lk_q  <= LK_IDLE;
                    end
                end
                default: begin
                    lk_q <= LK_IDLE;
                end
            endcase
        end
    end

    // ********************
    // pin sampling
    // ********************
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            sync1_q <= 16'h0000;
            sync2_q <= 16'h0000;
        end else begin
            sync1_q <= PAD_IN_I;
            sync2_q <= sync1_q;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            idata_q <= 16'h0000;
            AF_IN_O <= 16'h0000;
        end else begin
            idata_q <= sync2_q & ~pif.ana;
            AF_IN_O <= sync2_q & ~pif.ana;
        end
    end

    // ********************
    // pad multiplexer
    // ********************
    assign pif.mode   = mode_q;
    assign pif.otype  = otype_q;
    assign pif.pupd   = pupd_q;
    assign pif.odata  = odata_q;
    assign pif.afsel  = {afh_q, afl_q};
    assign pif.af_out = AF_OUT_I;
    assign pif.af_oe  = AF_OE_I;
    assign pif.force_off =
          (FAST_OSC_EN_I ? FAST_OSC_PINS : 16'h0000)
        | (SLOW_OSC_EN_I ? SLOW_OSC_PINS : 16'h0000)
        | ((CORE_OFF_I && !RTC_OWN_I) ? BACKUP_PINS : 16'h0000);

    gpp_pad_mux u_mux (
        .pif (pif)
    );

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            PAD_OUT_O   <= 16'h0000;
            PAD_OE_O    <= 16'h0000;
            PULL_UP_O   <= 16'h0000;
            PULL_DOWN_O <= 16'h0000;
            ANALOG_O    <= 16'h0000;
            SPEED_O     <= CFG_RST;
        end else begin
            PAD_OUT_O   <= pif.out;
            PAD_OE_O    <= pif.oe;
            PULL_UP_O   <= pif.pu;
            PULL_DOWN_O <= pif.pd;
            ANALOG_O    <= pif.ana;
            SPEED_O     <= speed_q;
        end
    end

    // ********************
    // read port
    // ********************
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            rdata_q <= 32'h0000_0000;
        end else if (!RD_I) begin
            rdata_q <= 32'h0000_0000;
        end else if (ADDR_I == OFS_MODE) begin
            rdata_q <= mode_q;
        end else if (ADDR_I == OFS_OTYPE) begin
            rdata_q <= {16'h0000, otype_q};
        end else if (ADDR_I == OFS_SPEED) begin
            rdata_q <= speed_q;
        end else if (ADDR_I == OFS_PUPD) begin
            rdata_q <= pupd_q;
        end else if (ADDR_I == OFS_IDATA) begin
            rdata_q <= {16'h0000, idata_q};
        end else if (ADDR_I == OFS_ODATA) begin
            rdata_q <= {16'h0000, odata_q};
        end else if (ADDR_I == OFS_LOCK && HAS_LOCK) begin
            rdata_q <= {15'h0000, key_q, lock_q};
        end else if (ADDR_I == OFS_AFL) begin
            rdata_q <= afl_q;
        end else if (ADDR_I == OFS_AFH) begin
            rdata_q <= afh_q;
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    assign RDATA_O = rdata_q;
endmodule : gpp_port

// file: testbench/gpp_pin_model.sv
// pin wire and outside driver model for the gpio port pads
`timescale 1ns/1ps
module gpp_pin_model (
    input  wire logic        clk_i,     // bench clock
    input  wire logic [15:0] out_i,     // pad drive level
    input  wire logic [15:0] oe_i,      // pad driver on
    input  wire logic [15:0] pu_i,      // weak pull-up on
    input  wire logic [15:0] pd_i,      // weak pull-down on
    input  wire logic [15:0] ext_en_i,  // outside driver on
    input  wire logic [15:0] ext_val_i, // outside driver level
    output logic      [15:0] pin_o      // resolved wire level
);
    logic [15:0] flt_q = 16'h5A5A;

    // floating wire toggles so no stale level reads back
    always_ff @(posedge clk_i) begin
        flt_q <= ~flt_q;
    end

    always_comb begin
        for (int p = 0; p < 16; p++) begin
            if (oe_i[p])
                pin_o[p] = out_i[p];
            else if (ext_en_i[p])
                pin_o[p] = ext_val_i[p];
            else if (pu_i[p] != pd_i[p])
                pin_o[p] = pu_i[p];
            else
                pin_o[p] = flt_q[p];
        end
    end
endmodule : gpp_pin_model

// file: testbench/gpp_port_asserts.sv
// concurrent checks on the gpio port top-level ports
`timescale 1ns/1ps
module gpp_port_asserts
    import gpp_pkg::*;
#(
    parameter bit          PORT_A        = 1'b1,     // debug pin resets
    parameter logic [15:0] FAST_OSC_PINS = 16'h0000, // fast osc pins
    parameter logic [15:0] SLOW_OSC_PINS = 16'h0000, // slow osc pins
    parameter logic [15:0] BACKUP_PINS   = 16'h0000  // backup pins
) (
    input wire logic              CLK_I,         // clock
    input wire logic              RESET_N_I,     // sync reset, low
    input wire logic [ADDR_W-1:0] ADDR_I,        // byte address
    input wire logic              RD_I,          // read strobe
    input wire logic [31:0]       RDATA_O,       // read data
    input wire logic [15:0]       PAD_OE_O,      // driver enable
    input wire logic [15:0]       PULL_UP_O,     // pull-up on
    input wire logic [15:0]       PULL_DOWN_O,   // pull-down on
    input wire logic [15:0]       ANALOG_O,      // analog state
    input wire logic              FAST_OSC_EN_I, // fast osc on
    input wire logic              SLOW_OSC_EN_I, // slow osc on
    input wire logic              CORE_OFF_I,    // core supply off
    input wire logic              RTC_OWN_I      // rtc owns backup
);
    localparam logic [15:0] PU_RST = PORT_A ? 16'h2000 : 16'h0000;
    localparam logic [15:0] PD_RST = PORT_A ? 16'h4000 : 16'h0000;

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);

    // ********************
    // properties
    // ********************
    property p_bsc_rd;
        RD_I && ADDR_I == OFS_BSC |=> RDATA_O == 32'h0;
    endproperty
    a_bsc_rd: assert property (p_bsc_rd)
        else $error("set/clear register read not zero");
    property p_clr_rd;
        RD_I && ADDR_I == OFS_CLR |=> RDATA_O == 32'h0;
    endproperty
    a_clr_rd: assert property (p_clr_rd)
        else $error("clear register read not zero");
    property p_ana_in;
        RD_I && ADDR_I == OFS_IDATA && ANALOG_O == $past(ANALOG_O)
            |=> (RDATA_O[15:0] & $past(ANALOG_O, 2)) == 16'h0;
    endproperty
    a_ana_in: assert property (p_ana_in)
        else $error("analog pin input bit not zero");
    property p_ana_off;
        (ANALOG_O & (PAD_OE_O | PULL_UP_O | PULL_DOWN_O)) == 16'h0;
    endproperty
    a_ana_off: assert property (p_ana_off)
        else $error("analog pin has driver or pull on");
    property p_pull_one;
        (PULL_UP_O & PULL_DOWN_O) == 16'h0;
    endproperty
    a_pull_one: assert property (p_pull_one)
        else $error("pull-up and pull-down on together");
    property p_osc;
        (FAST_OSC_EN_I && $past(FAST_OSC_EN_I)
            |-> &(ANALOG_O | ~FAST_OSC_PINS)) and
        (SLOW_OSC_EN_I && $past(SLOW_OSC_EN_I)
            |-> &(ANALOG_O | ~SLOW_OSC_PINS));
    endproperty
    a_osc: assert property (p_osc)
        else $error("oscillator pins not released by gpio");
    property p_backup;
        CORE_OFF_I && !RTC_OWN_I && $past(CORE_OFF_I) && !$past(RTC_OWN_I)
            |-> &(ANALOG_O | ~BACKUP_PINS);
    endproperty
    a_backup: assert property (p_backup)
        else $error("backup pins not analog with core off");
    property p_rst_cfg;
        $rose(RESET_N_I) |-> ##2 PULL_UP_O == PU_RST &&
            PULL_DOWN_O == PD_RST && (PAD_OE_O & 16'h9FFF) == 16'h0 &&
            ANALOG_O == 16'h0;
    endproperty
    a_rst_cfg: assert property (p_rst_cfg)
        else $error("pads not in reset configuration");

    c_bsc_rd: cover property (RD_I && ADDR_I == OFS_BSC);
    c_analog: cover property (ANALOG_O == 16'hFFFF);
    c_osc: cover property (FAST_OSC_EN_I && CORE_OFF_I);
endmodule : gpp_port_asserts

bind gpp_port gpp_port_asserts #(
    .PORT_A        (PORT_A),
    .FAST_OSC_PINS (FAST_OSC_PINS),
    .SLOW_OSC_PINS (SLOW_OSC_PINS),
    .BACKUP_PINS   (BACKUP_PINS)
) gpp_port_asserts_i (
    .CLK_I         (CLK_I),
    .RESET_N_I     (RESET_N_I),
    .ADDR_I        (ADDR_I),
    .RD_I          (RD_I),
    .RDATA_O       (RDATA_O),
    .PAD_OE_O      (PAD_OE_O),
    .PULL_UP_O     (PULL_UP_O),
    .PULL_DOWN_O   (PULL_DOWN_O),
    .ANALOG_O      (ANALOG_O),
    .FAST_OSC_EN_I (FAST_OSC_EN_I),
    .SLOW_OSC_EN_I (SLOW_OSC_EN_I),
    .CORE_OFF_I    (CORE_OFF_I),
    .RTC_OWN_I     (RTC_OWN_I)
);

// file: testbench/gpio_port_pin_control_bench.sv
// self-checking bench for the gpio port block
`timescale 1ns/1ps
module gpio_port_pin_control_bench;
    import gpp_pkg::*;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    localparam logic [31:0] RV [12] = '{MODE_RST_A, 32'h0, SPEED_RST_A,
        PUPD_RST_A, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    logic         clk, rst_n, wr, rd, fosc, sosc, coff, rtc;
    logic         rd_d = 1'b0;
    logic [5:0]   addr;
    logic [31:0]  wdata, rdata, speed;
    logic [15:0]  pin, pout, poe, pu, pd, ana, afin, ext_en, ext_val;
    logic [15:0]  r, s, c, e, o, seed = 16'h7B1A;
    logic [127:0] af_out, af_oe;
    logic [31:0]  exp_q[$], msk_q[$];
    int           n_fail = 0, comparisons = 0;

    gpp_port #(
        .FAST_OSC_PINS (16'h0001),
        .SLOW_OSC_PINS (16'h0002),
        .BACKUP_PINS   (16'hE000)
    ) gpp_port_i (
        .CLK_I (clk), .RESET_N_I (rst_n), .ADDR_I (addr),
        .WDATA_I (wdata), .WR_I (wr), .RD_I (rd), .RDATA_O (rdata),
        .PAD_IN_I (pin), .PAD_OUT_O (pout), .PAD_OE_O (poe),
        .PULL_UP_O (pu), .PULL_DOWN_O (pd), .ANALOG_O (ana),
        .SPEED_O (speed), .AF_IN_O (afin), .AF_OUT_I (af_out),
        .AF_OE_I (af_oe), .FAST_OSC_EN_I (fosc), .SLOW_OSC_EN_I (sosc),
        .CORE_OFF_I (coff), .RTC_OWN_I (rtc)
    );
    gpp_pin_model gpp_pin_model_i (
        .clk_i (clk), .out_i (pout), .oe_i (poe), .pu_i (pu), .pd_i (pd),
        .ext_en_i (ext_en), .ext_val_i (ext_val), .pin_o (pin)
    );

    // ********************
    // tasks
    // ********************
    function automatic logic [15:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction : rnd
    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [31:0] d);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
    endtask : bus
    task automatic rdx(input logic [5:0] a, input logic [31:0] x,
                       input logic [31:0] m);
        exp_q.push_back(x);
        msk_q.push_back(m);
        bus(1'b0, a, 32'h0);
    endtask : rdx
    task automatic idle(input int n);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (n) @(posedge clk);
    endtask : idle
    task automatic chk(input string nm, input logic [63:0] x,
                       input logic [63:0] g);
        comparisons++;
        if (g !== x) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, x, g);
        end
    endtask : chk
    // {oe, pull-up, pull-down, analog}, masked drive
    task automatic pads(input logic [63:0] x, input logic [15:0] ov,
                        input logic [15:0] om);
        @(negedge clk);
        chk("pads", x, {poe, pu, pd, ana});
        chk("pad_out", ov & om, pout & om);
        @(posedge clk);
    endtask : pads
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run

    // read data checked the cycle after the strobe
    always @(posedge clk) begin
        if (rd_d && exp_q.size() > 0) begin
            chk("rdata", exp_q[0] & msk_q[0], rdata & msk_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
        rd_d <= rd && rst_n;
    end

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #100000;
        n_fail++;
        complete_run();
    end

    // ********************
    // tests
    // ********************
    initial begin
        {rst_n, wr, rd, fosc, sosc, coff, rtc} = '0;
        {addr, wdata, ext_en, ext_val, af_out, af_oe} = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        idle(3);
        for (int i = 0; i < 12; i++)
            rdx(6'(i * 4), RV[i], (i == 4) ? 32'h0 : ALL);
        rdx(6'h02, 32'h0, ALL);
        idle(1);
        @(negedge clk);
        chk("speed", SPEED_RST_A, speed);
        pads({16'h0, 16'h2000, 16'h4000, 16'h0}, 0, 0);
        $display("test reset done");
        bus(1'b1, OFS_MODE, 32'h5555_5555);
        r = rnd();
        bus(1'b1, OFS_ODATA, {16'h0, r});
        idle(1);
        pads({16'hFFFF, 16'h2000, 16'h4000, 16'h0}, r, 16'hFFFF);
        idle(4);
        rdx(OFS_ODATA, {16'h0, r}, ALL);
        rdx(OFS_IDATA, {16'h0, r}, ALL);
        e = r;
        for (int i = 0; i < 4; i++) begin
            s = rnd();
            c = (i == 0) ? s : rnd();
            e = (e & ~c) | s;
            bus(1'b1, OFS_BSC, {c, s});
            c = rnd();
            e = e & ~c;
            bus(1'b1, OFS_CLR, {rnd(), c});
            rdx(OFS_ODATA, {16'h0, e}, ALL);
        end
        rdx(OFS_BSC, 32'h0, ALL);
        rdx(OFS_CLR, 32'h0, ALL);
        idle(1);
        pads({16'hFFFF, 16'h2000, 16'h4000, 16'h0}, e, 16'hFFFF);
        $display("test output done");
        bus(1'b1, OFS_OTYPE, 32'h0000_FFFF);
        bus(1'b1, OFS_PUPD, 32'h5555_5555);
        r = rnd();
        bus(1'b1, OFS_ODATA, {16'h0, r});
        idle(1);
        pads({~r, 16'hFFFF, 16'h0, 16'h0}, 0, 0);
        idle(4);
        rdx(OFS_IDATA, {16'h0, r}, ALL);
        bus(1'b1, OFS_OTYPE, 32'h0);
        bus(1'b1, OFS_PUPD, 32'h0);
        bus(1'b1, OFS_MODE, 32'hAAAA_AAAA);
        for (int f = 0; f < 9; f++) begin
            for (int j = 0; j < 8; j++) begin
                af_out[16*j +: 16] <= rnd();
                af_oe[16*j +: 16] <= rnd();
            end
            bus(1'b1, OFS_AFL, 32'h1111_1111 * f);
            bus(1'b1, OFS_AFH, 32'h1111_1111 * f);
            idle(1);
            for (int p = 0; p < 16; p++) begin
                o[p] = (f < 8) && af_out[8*p+f];
                e[p] = (f < 8) && af_oe[8*p+f];
            end
            pads({e, 48'h0}, o, e);
        end
        rdx(OFS_AFH, 32'h8888_8888, ALL);
        $display("test alternate done");
        bus(1'b1, OFS_PUPD, 32'h5555_5555);
        bus(1'b1, OFS_MODE, 32'hFFFF_FFFF);
        ext_en <= 16'hFFFF;
        ext_val <= 16'hFFFF;
        idle(1);
        pads({48'h0, 16'hFFFF}, 0, 0);
        idle(4);
        rdx(OFS_IDATA, 32'h0, ALL);
        bus(1'b1, OFS_PUPD, 32'hAAAA_AAAA);
        bus(1'b1, OFS_MODE, 32'h0);
        for (int i = 0; i < 2; i++) begin
            r = rnd();
            ext_val <= r;
            idle(1);
            pads({32'h0, 16'hFFFF, 16'h0}, 0, 0);
            idle(3);
            @(negedge clk);
            chk("af_in", r, afin);
            @(posedge clk);
            rdx(OFS_IDATA, {16'h0, r}, ALL);
        end
        ext_en <= 16'h0;
        bus(1'b1, OFS_MODE, 32'h5555_5555);
        {fosc, sosc, coff} <= 3'h7;
        idle(2);
        pads({16'h1FFC, 16'h0, 16'h1FFC, 16'hE003}, 0, 0);
        {fosc, sosc, rtc} <= 3'h1;
        idle(2);
        pads({16'hFFFF, 16'h0, 16'hFFFF, 16'h0}, 0, 0);
        $display("test input analog done");
        bus(1'b1, OFS_LOCK, 32'h0000_00FF);
        bus(1'b1, OFS_LOCK, 32'h0001_00FF);
        bus(1'b1, OFS_LOCK, 32'h0000_00FF);
        bus(1'b1, OFS_LOCK, 32'h0001_00FF);
        rdx(OFS_LOCK, 32'h0, 32'h0);
        rdx(OFS_LOCK, 32'h0001_00FF, ALL);
        bus(1'b1, OFS_LOCK, 32'h0000_FFFF);
        bus(1'b1, OFS_MODE, 32'h0);
        rdx(OFS_LOCK, 32'h0001_00FF, ALL);
        rdx(OFS_MODE, 32'h0000_5555, ALL);
        idle(1);
        rst_n <= 1'b0;
        idle(2);
        rst_n <= 1'b1;
        idle(3);
        rdx(OFS_LOCK, 32'h0, ALL);
        rdx(OFS_MODE, MODE_RST_A, ALL);
        idle(2);
        $display("test lock done");
        complete_run();
    end
endmodule : gpio_port_pin_control_bench
